// ===== design/dsl_pkg.sv
package dsl_pkg;

  // ----------------------------------------------------------------
  // Converter code
  // ----------------------------------------------------------------
  localparam int CODE_W = 16;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic [4:0] FULL_FRAME_BITS = 5'h10;

  // ----------------------------------------------------------------
  // Register port map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] INPUT_OFS = 4'h4;
  localparam logic [3:0] OUTPUT_OFS = 4'h8;
  localparam logic [3:0] STATUS_OFS = 4'hC;

  // CTRL fields
  localparam int CTRL_PDOWN_BIT = 0;
  localparam int CTRL_SWLOAD_BIT = 1;
  localparam logic CTRL_PDOWN_RST = 1'b0;

  // STATUS fields
  localparam int STAT_STRAP_BIT = 0;
  localparam int STAT_SHORT_BIT = 1;
  localparam int STAT_PDOWN_BIT = 2;
  localparam int STAT_FCNT_LSB = 8;
  localparam int FCNT_W = 8;
  localparam logic [7:0] FCNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Link-side snapshot handed across at frame end
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] code;
    logic [4:0] bits;
  } dsl_frame_s;

  typedef enum logic [1:0] {
    DSL_IDLE,
    DSL_FRAME,
    DSL_CAPTURE
  } dsl_link_e;

endpackage : dsl_pkg

// ===== design/dsl_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser; first stage is read only by the second
module dsl_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : dsl_sync2

// ===== design/dsl_link_shift.sv
`timescale 1ns/1ps
// Serial shifter running on the link clock
module dsl_link_shift (
  input wire logic sclk_in,
  input wire logic rst_b_in,
  input wire logic select_n_in,
  input wire logic sdi_in,
  output dsl_pkg::dsl_frame_s frame_out,
  output logic sdo_out
);

  logic [15:0] shift_reg;
  logic [4:0] bits_reg;
  logic first_reg;
  logic frame_rst_b;

  // Select high holds the frame-start flag set, so stray clocks are ignored
  assign frame_rst_b = rst_b_in & ~select_n_in;

  // ----------------------------------------------------------------
  // Frame-start flag
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_in or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
      first_reg <= 1'b1; // [RQ11]
    else
      first_reg <= 1'b0; // [RQ1]
  end

  // ----------------------------------------------------------------
  // Data shift, MSB first, sampled on rising clock
  // ----------------------------------------------------------------
  // Shift register is not cleared per frame so old data can chain out
  always_ff @(posedge sclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      shift_reg <= dsl_pkg::ZERO_CODE;
    else if (!select_n_in)
      shift_reg <= {shift_reg[14:0], sdi_in}; // [RQ1] [RQ6]
  end

  // Bit count restarts on the first clock of each frame and saturates
  always_ff @(posedge sclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      bits_reg <= 5'h00;
    else if (select_n_in)
      bits_reg <= bits_reg; // [RQ11]
    else if (first_reg)
      bits_reg <= 5'h01;
    else if (bits_reg != dsl_pkg::FULL_FRAME_BITS)
      bits_reg <= bits_reg + 5'h01;
  end

  // ----------------------------------------------------------------
  // Serial out changes on the falling clock, half a bit ahead of sampling
  // ----------------------------------------------------------------
  always_ff @(negedge sclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sdo_out <= 1'b0;
    else if (!select_n_in)
      sdo_out <= shift_reg[15]; // [RQ5]
  end

  assign frame_out.code = shift_reg;
  assign frame_out.bits = bits_reg;

endmodule : dsl_link_shift

// ===== design/dsl_top.sv
`timescale 1ns/1ps
//
// Behaviour
// [RQ1] Select falling starts bit intake and bit output, both on serial clock.
// [RQ2] Load strobe low copies the input register into the output register.
// [RQ3] Clear low asynchronously forces the output to the strap power-up value.
// [RQ4] Strap low gives zero code, strap high gives mid-scale code.
// [RQ5] Serial output drives shifted data for daisy chain or read-back.
// [RQ6] Code is 16 bits in an input register and an output register.
// [RQ7] Power-on reset puts the output register at the strap value.
// [RQ8] A power-down state lowers consumption while idle.
// [RQ9] Host keeps the serial clock at or below 20 MHz.
// [RQ10] Host may share one load strobe among several converters.
// [RQ11] Frame ends when select rises; clock and data ignored while high.
// [RQ12] Host pulses load strobe only after a complete frame has ended.
//
module dsl_top (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic sclk_in,
  input wire logic select_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  input wire logic load_strobe_n_in,
  input wire logic async_clear_n_in,
  input wire logic powerup_value_sel_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic [15:0] analog_out_code_out,
  output logic power_down_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dsl_pkg::dsl_frame_s link_frame;
  dsl_pkg::dsl_link_e link_state_reg;
  dsl_pkg::dsl_link_e link_state_next;
  logic [1:0] pins_sync;
  logic select_n_sync;
  logic load_n_sync;
  logic strap_sync;
  logic load_n_prev_reg;
  logic load_req;
  logic frame_done;
  logic strap_reg;
  logic [15:0] input_reg;
  logic [14:0] out_low_reg;
  logic out_msb_zero_reg;
  logic out_msb_mid_reg;
  logic out_msb;
  logic out_rst_b;
  logic short_reg;
  logic [7:0] fcnt_reg;
  logic pdown_reg;
  logic swload_reg;
  logic ctrl_wr;
  logic status_wr;
  logic [31:0] rdata_next;
  logic [15:0] snap_code_reg;
  logic snap_full_reg;
  logic commit_reg;

  // ----------------------------------------------------------------
  // Link-clock logic
  // ----------------------------------------------------------------
  // Everything touching the serial clock lives in this instance
  dsl_link_shift u_link (
    .sclk_in(sclk_in),
    .rst_b_in(rst_b_in),
    .select_n_in(select_n_in),
    .sdi_in(sdi_in),
    .frame_out(link_frame),
    .sdo_out(sdo_out)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Select and load strobe idle high, so they leave reset high; a low
  // reset value would read as a frame and a load after every reset.
  dsl_sync2 #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .async_in({select_n_in, load_strobe_n_in}),
    .sync_out(pins_sync)
  );

  // The strap leaves reset low, the level that strap_reg resets to
  dsl_sync2 #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_strap_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .async_in(powerup_value_sel_in),
    .sync_out(strap_sync)
  );

  assign select_n_sync = pins_sync[1];
  assign load_n_sync = pins_sync[0];

  // ----------------------------------------------------------------
  // Frame tracking state machine
  // ----------------------------------------------------------------
  // The snapshot is taken only once select is seen high again; by then
  // the serial clock is parked, so the shifter's flops stand still.
  always_comb
  begin
    link_state_next = link_state_reg;
    case (link_state_reg)
      dsl_pkg::DSL_IDLE:
      begin
        if (!select_n_sync)
          link_state_next = dsl_pkg::DSL_FRAME; // [RQ1]
      end
      dsl_pkg::DSL_FRAME:
      begin
        if (select_n_sync)
          link_state_next = dsl_pkg::DSL_CAPTURE; // [RQ11]
      end
      dsl_pkg::DSL_CAPTURE:
      begin
        link_state_next = dsl_pkg::DSL_IDLE;
      end
      default:
      begin
        link_state_next = dsl_pkg::DSL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      link_state_reg <= dsl_pkg::DSL_IDLE;
    else
      link_state_reg <= link_state_next;
  end

  assign frame_done = (link_state_reg == dsl_pkg::DSL_CAPTURE);

  // ----------------------------------------------------------------
  // Frame snapshot
  // ----------------------------------------------------------------
  // The link word is copied once, while the serial clock is parked, into
  // flops of this domain; the length compare runs at that same edge on the
  // link's bit count wires, and only its one-bit result is registered.
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      snap_code_reg <= dsl_pkg::ZERO_CODE;
      snap_full_reg <= 1'b0;
    end
    else if (frame_done)
    begin
      snap_code_reg <= link_frame.code; // [RQ11]
      snap_full_reg <= (link_frame.bits == dsl_pkg::FULL_FRAME_BITS);
    end
  end

  // Snapshot is acted upon one cycle after it is taken
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      commit_reg <= 1'b0;
    else
      commit_reg <= frame_done;
  end

  // ----------------------------------------------------------------
  // Input register
  // ----------------------------------------------------------------
  // Only a frame of sixteen bits or more updates it; the last sixteen
  // bits shifted in are the code, earlier ones went out to the chain.
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      input_reg <= dsl_pkg::ZERO_CODE;
    else if (commit_reg && snap_full_reg)
      input_reg <= snap_code_reg; // [RQ6] [RQ11]
  end

  // Short frames are flagged; frame end sets, write-one clears, set wins
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      short_reg <= 1'b0;
    else if (commit_reg && !snap_full_reg)
      short_reg <= 1'b1;
    else if (status_wr && reg_wdata_in[dsl_pkg::STAT_SHORT_BIT])
      short_reg <= 1'b0;
  end

  // Frame counter wraps; useful to see that the host reached the part
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      fcnt_reg <= dsl_pkg::FCNT_RST;
    else if (commit_reg)
      fcnt_reg <= fcnt_reg + 8'h01;
  end

  // ----------------------------------------------------------------
  // Load strobe
  // ----------------------------------------------------------------
  // Falling edge of the synchronised strobe; a strobe held low loads
  // once. A shared strobe thus updates all parts together.
  // The edge is taken after the synchroniser, never from the raw pin.
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      load_n_prev_reg <= 1'b1;
    else
      load_n_prev_reg <= load_n_sync;
  end

  assign load_req = (load_n_prev_reg && !load_n_sync) || swload_reg; // [RQ2]

  // ----------------------------------------------------------------
  // Strap
  // ----------------------------------------------------------------
  // A tied pin, tracked continuously once the synchroniser has filled
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      strap_reg <= 1'b0;
    else
      strap_reg <= strap_sync; // [RQ4]
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Power-on reset and clear both act without the clock. The zero and
  // mid-scale codes differ only in the top bit, so the top bit is kept
  // in two flops reset to 0 and 1 and the strap picks between them.
  assign out_rst_b = rst_b_in & async_clear_n_in; // [RQ3] [RQ7]

  always_ff @(posedge sys_clk_in or negedge out_rst_b)
  begin
    if (!out_rst_b)
      out_low_reg <= dsl_pkg::ZERO_CODE[14:0]; // [RQ3] [RQ7]
    else if (load_req)
      out_low_reg <= input_reg[14:0]; // [RQ2]
  end

  always_ff @(posedge sys_clk_in or negedge out_rst_b)
  begin
    if (!out_rst_b)
      out_msb_zero_reg <= dsl_pkg::ZERO_CODE[15]; // [RQ4]
    else if (load_req)
      out_msb_zero_reg <= input_reg[15];
  end

  always_ff @(posedge sys_clk_in or negedge out_rst_b)
  begin
    if (!out_rst_b)
      out_msb_mid_reg <= dsl_pkg::MID_CODE[15]; // [RQ4]
    else if (load_req)
      out_msb_mid_reg <= input_reg[15];
  end

  assign out_msb = strap_reg ? out_msb_mid_reg : out_msb_zero_reg; // [RQ4]
  assign analog_out_code_out = {out_msb, out_low_reg}; // [RQ6]

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  assign ctrl_wr = reg_wr_in && (reg_addr_in == dsl_pkg::CTRL_OFS);
  assign status_wr = reg_wr_in && (reg_addr_in == dsl_pkg::STATUS_OFS);

  // Power-down only gates the converter; codes still load meanwhile
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pdown_reg <= dsl_pkg::CTRL_PDOWN_RST;
    else if (ctrl_wr)
      pdown_reg <= reg_wdata_in[dsl_pkg::CTRL_PDOWN_BIT]; // [RQ8]
  end

  assign power_down_out = pdown_reg; // [RQ8]

  // Software load is a one-cycle pulse; the bit reads back as zero
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      swload_reg <= 1'b0;
    else
      swload_reg <= ctrl_wr && reg_wdata_in[dsl_pkg::CTRL_SWLOAD_BIT];
  end

  // Read mux; unmapped addresses read zero
  // Decoded from the live address, so the reply shows the strobe cycle
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (reg_addr_in)
      dsl_pkg::CTRL_OFS:
      begin
        rdata_next[dsl_pkg::CTRL_PDOWN_BIT] = pdown_reg;
      end
      dsl_pkg::INPUT_OFS:
      begin
        rdata_next[15:0] = input_reg;
      end
      dsl_pkg::OUTPUT_OFS:
      begin
        rdata_next[15:0] = analog_out_code_out;
      end
      dsl_pkg::STATUS_OFS:
      begin
        rdata_next[dsl_pkg::STAT_STRAP_BIT] = strap_reg;
        rdata_next[dsl_pkg::STAT_SHORT_BIT] = short_reg;
        rdata_next[dsl_pkg::STAT_PDOWN_BIT] = pdown_reg;
        rdata_next[15:8] = fcnt_reg;
      end
      default:
      begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= rdata_next;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

endmodule : dsl_top

// ===== bench/dsl_monitor.sv
`timescale 1ns/1ps
// Watches the register port and the output code of the converter control
module dsl_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic load_strobe_n_in,
  input wire logic async_clear_n_in,
  input wire logic powerup_value_sel_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [15:0] analog_out_code_out,
  input wire logic power_down_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------------------------------
  // Output code
  // ----------------------------------------------------------------
  // Strap must have been steady long enough to pass its synchroniser
  a_clear_forces_strap: assert property (
    !async_clear_n_in && $past(powerup_value_sel_in, 4) == powerup_value_sel_in
    |-> analog_out_code_out == (powerup_value_sel_in ?
      dsl_pkg::MID_CODE : dsl_pkg::ZERO_CODE))
    else $error("clear did not force the strap code");
  a_code_has_cause: assert property (
    $changed(analog_out_code_out) |-> !$past(load_strobe_n_in, 3)
    || !$past(load_strobe_n_in, 4) || !async_clear_n_in
    || !$past(async_clear_n_in) || $past(reg_wr_in, 2)
    || !$past(rst_b_in, 3) || !$past(rst_b_in, 4))
    else $error("output code changed with no load, clear or reset");
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  a_rdata_idle_zero: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_read_output_code: assert property (
    reg_rd_in && reg_addr_in == dsl_pkg::OUTPUT_OFS ##1
    $stable(analog_out_code_out)
    |-> reg_rdata_out == {16'h0000, analog_out_code_out})
    else $error("output register read-back wrong");
  a_unmapped_zero: assert property (
    reg_rd_in && reg_addr_in[1:0] != 2'h0 |=> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_strap_status: assert property (
    reg_rd_in && reg_addr_in == dsl_pkg::STATUS_OFS
    && $past(powerup_value_sel_in, 4) == powerup_value_sel_in
    |=> reg_rdata_out[0] == $past(powerup_value_sel_in))
    else $error("strap status bit wrong");
  a_pdown_write: assert property (
    reg_wr_in && reg_addr_in == dsl_pkg::CTRL_OFS
    |=> power_down_out == $past(reg_wdata_in[0]))
    else $error("power-down not written");
  a_pdown_hold: assert property (
    !(reg_wr_in && reg_addr_in == dsl_pkg::CTRL_OFS)
    |=> $stable(power_down_out))
    else $error("power-down changed without a write");
  c_load: cover property ($fell(load_strobe_n_in));
  c_clear_mid: cover property (!async_clear_n_in && powerup_value_sel_in);
  c_status: cover property (reg_rd_in && reg_addr_in == dsl_pkg::STATUS_OFS);
endmodule : dsl_monitor

bind dsl_top dsl_monitor dsl_monitor_inst (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .load_strobe_n_in(load_strobe_n_in), .async_clear_n_in(async_clear_n_in),
  .powerup_value_sel_in(powerup_value_sel_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .analog_out_code_out(analog_out_code_out),
  .power_down_out(power_down_out));

// ===== bench/dsl_host_model.sv
`timescale 1ns/1ps
// Serial host: frames at 8 MHz, samples the return line on rising edges
module dsl_host_model (
  output logic sclk_out,
  output logic select_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  localparam realtime HALF = 62.5; // 125 ns period, under 20 MHz
  // Link clock stands still low between frames
  initial
  begin
    sclk_out = 1'b0;
    select_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // One frame of n bits, MSB first
  task automatic send(input logic [31:0] d, input int n,
    output logic [31:0] got);
    got = 32'h0;
    #(HALF / 3);
    select_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_out = d[i];
      #HALF;
      sclk_out = 1'b1;
      got = {got[30:0], sdo_in};
      #HALF;
      sclk_out = 1'b0;
    end
    #HALF;
    select_n_out = 1'b1; // Ends only after the last bit
    sdi_out = ~sdi_out; // Released line must not keep a stale level
  endtask : send
  // Deliberate misuse: clock pulses while deselected
  task automatic stray(input int n);
    for (int i = 0; i < n; i++)
    begin
      sdi_out = ~sdi_out;
      #HALF;
      sclk_out = 1'b1;
      #HALF;
      sclk_out = 1'b0;
    end
  endtask : stray
endmodule : dsl_host_model

// ===== bench/dac_serial_load_control_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module dac_serial_load_control_test;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic load_strobe_n_in = 1'b1;
  logic async_clear_n_in = 1'b1;
  logic powerup_value_sel_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic sclk, select_n, sdi, sdo_out, power_down_out;
  logic [31:0] reg_rdata_out, rd_val, got, rnd;
  logic [15:0] analog_out_code_out, code, exp_sh;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int sh_known = 16; // Reset clears the shift register, so it starts known
  always #5 sys_clk_in = ~sys_clk_in;
  dsl_top dsl_top_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .sclk_in(sclk), .select_n_in(select_n), .sdi_in(sdi), .sdo_out(sdo_out),
    .load_strobe_n_in(load_strobe_n_in), .async_clear_n_in(async_clear_n_in),
    .powerup_value_sel_in(powerup_value_sel_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .analog_out_code_out(analog_out_code_out),
    .power_down_out(power_down_out));
  dsl_host_model dsl_host_model_inst (.sclk_out(sclk), .select_n_out(select_n),
    .sdi_out(sdi), .sdo_in(sdo_out));
  // ----------------------------------------------------------------
  // Bus and link tasks
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : reg_rd
  // Return line must replay the older shift contents, bit for bit
  task automatic frame(input logic [31:0] d, input int n);
    dsl_host_model_inst.send(d, n, got);
    for (int i = n - 1; i >= 0; i--)
    begin
      if (sh_known >= 16) `CHK(got[i], exp_sh[15])
      exp_sh = {exp_sh[14:0], d[i]};
      sh_known++;
    end
    repeat (8) @(posedge sys_clk_in);
  endtask : frame
  task automatic pulse_load;
    @(posedge sys_clk_in);
    load_strobe_n_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    load_strobe_n_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
  endtask : pulse_load
  // Code that reset and clear must leave, picked by the strap
  function automatic logic [15:0] strap_code(input logic sel);
    return sel ? dsl_pkg::MID_CODE : dsl_pkg::ZERO_CODE;
  endfunction : strap_code
  task report_and_stop;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // Hang guard, well above the expected run of some 2400 cycles
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(97));
    exp_sh = dsl_pkg::ZERO_CODE;
    repeat (10) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    `CHK(analog_out_code_out, strap_code(1'b0))
    // Random codes, each loaded by the strobe; last loop uses 24 bits
    for (int k = 0; k < 7; k++)
    begin
      rnd = $urandom();
      frame(k == 6 ? {8'h00, rnd[23:0]} : {16'h0, rnd[15:0]}, k == 6 ? 24 : 16);
      code = rnd[15:0];
      reg_rd(dsl_pkg::INPUT_OFS, rd_val);
      `CHK(rd_val, {16'h0, code})
      pulse_load();
      `CHK(analog_out_code_out, code)
    end
    // Short frame and stray clocks leave the input register alone
    frame(32'h0000_01A5, 9);
    dsl_host_model_inst.stray(5);
    repeat (8) @(posedge sys_clk_in);
    reg_rd(dsl_pkg::INPUT_OFS, rd_val);
    `CHK(rd_val, {16'h0, code})
    reg_rd(dsl_pkg::STATUS_OFS, rd_val);
    `CHK(rd_val[1], 1'b1)
    `CHK(rd_val[15:8], 8'h08)
    `CHK(rd_val[0], 1'b0)
    reg_wr(dsl_pkg::STATUS_OFS, 32'h0000_0002);
    reg_rd(dsl_pkg::STATUS_OFS, rd_val);
    `CHK(rd_val[1], 1'b0)
    // Clear forces the strap code; a later load restores the input
    async_clear_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    `CHK(analog_out_code_out, strap_code(1'b0))
    async_clear_n_in <= 1'b1;
    pulse_load();
    `CHK(analog_out_code_out, code)
    // Software load, power-down, read-back and an unmapped place
    frame(32'h0000_7E81, 16);
    reg_wr(dsl_pkg::CTRL_OFS, 32'h0000_0003);
    repeat (3) @(posedge sys_clk_in);
    `CHK(analog_out_code_out, 16'h7E81)
    `CHK(power_down_out, 1'b1)
    reg_rd(dsl_pkg::OUTPUT_OFS, rd_val);
    `CHK(rd_val, 32'h0000_7E81)
    reg_wr(dsl_pkg::CTRL_OFS, 32'h0000_0000);
    reg_rd(4'h1, rd_val);
    `CHK(rd_val, 32'h0)
    `CHK(power_down_out, 1'b0)
    // Second reset with the strap high selects mid-scale
    rst_b_in <= 1'b0;
    powerup_value_sel_in <= 1'b1;
    sh_known = 16;
    exp_sh = dsl_pkg::ZERO_CODE;
    repeat (10) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    `CHK(analog_out_code_out, strap_code(1'b1))
    reg_rd(dsl_pkg::STATUS_OFS, rd_val);
    `CHK(rd_val[0], 1'b1)
    `CHK(rd_val[15:8], dsl_pkg::FCNT_RST)
    frame(32'h0000_1234, 16);
    pulse_load();
    `CHK(analog_out_code_out, 16'h1234)
    async_clear_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    `CHK(analog_out_code_out, strap_code(1'b1))
    async_clear_n_in <= 1'b1;
    report_and_stop();
  end
endmodule : dac_serial_load_control_test
